// >>> logic/iopu_top.sv
// io port block: apb registers, pin drive, pull-ups, sleep and wake-up
//
// Overview of operation
// - pins synchronised in two stages, sampled at the end of the read setup phase
// - output latch holds until rewritten or a watchdog timeout while running
// - pull-up only on input with enable set
// - port a bit seven has no pull-up
// - sleep bit write enters sleep, sleep_mode raised
// - enabled port a falling edge wakes sleep
// - wake enable bits, one enables, reset zero
// - port a direction, one input, reset ones
// - port a pull-up bits, reset zero
// - port b direction two bits, reset ones
// - port b pull-up two bits, reset zero
// - unimplemented bits read as zero
// - output pins read back the latch
// - input pins read the pin level
`timescale 1ns/1ps
`include "iopu_defines.svh"

module iopu_top #(
  parameter int PA_WIDTH = `IOPU_PA_WIDTH,
  parameter int PB_WIDTH = `IOPU_PB_WIDTH
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`IOPU_ADDR_WIDTH-1:0] paddr,
  input  wire logic [`IOPU_DATA_WIDTH-1:0] pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [`IOPU_DATA_WIDTH-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        wdt_timeout,
  input  wire logic [PA_WIDTH-1:0]         porta_pin_in,
  output logic      [PA_WIDTH-1:0]         porta_pin_out,
  output logic      [PA_WIDTH-1:0]         porta_pin_oe,
  output logic      [PA_WIDTH-1:0]         porta_pullup_on,
  input  wire logic [PB_WIDTH-1:0]         portb_pin_in,
  output logic      [PB_WIDTH-1:0]         portb_pin_out,
  output logic      [PB_WIDTH-1:0]         portb_pin_oe,
  output logic      [PB_WIDTH-1:0]         portb_pullup_on,
  output logic                             sleep_mode,
  output logic                             wake_event,
  output logic                             irq
);
  import iopu_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (PA_WIDTH != `IOPU_PA_WIDTH || PB_WIDTH != `IOPU_PB_WIDTH) begin : g_chk
    $error("iopu_top: port widths must match the register layout");
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [`IOPU_ADDR_WIDTH-1:0] a,
                               input logic [`IOPU_ADDR_WIDTH-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // mixes pin levels for inputs with latch values for outputs
  function automatic logic [`IOPU_PA_WIDTH-1:0] port_view(
      input logic [`IOPU_PA_WIDTH-1:0] dir,
      input logic [`IOPU_PA_WIDTH-1:0] pin,
      input logic [`IOPU_PA_WIDTH-1:0] latch);
    port_view = (dir & pin) | (~dir & latch);
  endfunction

  iopu_state_t state;
  iopu_state_t next_state;

  logic setup_phase;
  logic wr_en;
  logic wr_lane0;
  logic mapped;
  logic [`IOPU_PA_WIDTH-1:0] pin_fall;
  logic [`IOPU_PA_WIDTH-1:0] pa_pad_b;
  logic [`IOPU_PA_WIDTH-1:0] pb_view;
  logic [`IOPU_IRQ_WIDTH-1:0] irq_set;
  logic pin_wake;
  logic wdt_sleep;

  assign setup_phase = psel & ~penable;
  assign wr_en       = psel & penable & pwrite;
  assign wr_lane0    = wr_en & pstrb[0];
  assign mapped      = hit(paddr, `IOPU_OFS_PA_DATA)  |
                       hit(paddr, `IOPU_OFS_PB_DATA)  |
                       hit(paddr, `IOPU_OFS_PA_DIR)   |
                       hit(paddr, `IOPU_OFS_PB_DIR)   |
                       hit(paddr, `IOPU_OFS_PA_PU)    |
                       hit(paddr, `IOPU_OFS_PB_PU)    |
                       hit(paddr, `IOPU_OFS_PA_WAKE)  |
                       hit(paddr, `IOPU_OFS_IRQ_STAT) |
                       hit(paddr, `IOPU_OFS_IRQ_MASK) |
                       hit(paddr, `IOPU_OFS_SLEEP);

  // falling edges seen on the synchronised port a levels
  assign pin_fall  = state.pa_prev & ~state.pa_sync;
  assign pin_wake  = (state.power == IOPU_SLEEP) &&
                     ((pin_fall & state.pa_wake) != '0);
  assign wdt_sleep = wdt_timeout && (state.power == IOPU_SLEEP);
  assign pa_pad_b  = {{(`IOPU_PA_WIDTH-`IOPU_PB_WIDTH){1'b0}},
                      state.pb_data};
  assign pb_view   = port_view(
      {{(`IOPU_PA_WIDTH-`IOPU_PB_WIDTH){1'b0}}, state.pb_dir},
      {{(`IOPU_PA_WIDTH-`IOPU_PB_WIDTH){1'b0}}, state.pb_sync},
      pa_pad_b);

  always_comb begin
    irq_set = '0;
    irq_set[`IOPU_IRQ_PIN_WAKE] = pin_wake;
    irq_set[`IOPU_IRQ_WDT_WAKE] = wdt_sleep;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    // two-stage synchronisers for the pins
    next_state.pa_meta = porta_pin_in;
    next_state.pa_sync = state.pa_meta;
    next_state.pa_prev = state.pa_sync;
    next_state.pb_meta = portb_pin_in;
    next_state.pb_sync = state.pb_meta;

    // read data captured at the edge that opens the access phase
    if (setup_phase) begin
      next_state.slverr = ~mapped;
      next_state.rdata  = '0;
      if (!pwrite) begin
        case (1'b1)
          hit(paddr, `IOPU_OFS_PA_DATA):
            next_state.rdata[`IOPU_PA_WIDTH-1:0] = port_view(
                state.pa_dir, state.pa_sync, state.pa_data);
          hit(paddr, `IOPU_OFS_PB_DATA):
            next_state.rdata[`IOPU_PA_WIDTH-1:0] = pb_view;
          hit(paddr, `IOPU_OFS_PA_DIR):
            next_state.rdata[`IOPU_PA_WIDTH-1:0] = state.pa_dir;
          hit(paddr, `IOPU_OFS_PB_DIR):
            next_state.rdata[`IOPU_PB_WIDTH-1:0] = state.pb_dir;
          hit(paddr, `IOPU_OFS_PA_PU):
            next_state.rdata[`IOPU_PA_WIDTH-1:0] =
                state.pa_pu & `IOPU_PA_PU_MASK;
          hit(paddr, `IOPU_OFS_PB_PU):
            next_state.rdata[`IOPU_PB_WIDTH-1:0] = state.pb_pu;
          hit(paddr, `IOPU_OFS_PA_WAKE):
            next_state.rdata[`IOPU_PA_WIDTH-1:0] = state.pa_wake;
          hit(paddr, `IOPU_OFS_IRQ_STAT):
            next_state.rdata[`IOPU_IRQ_WIDTH-1:0] = state.irq_stat;
          hit(paddr, `IOPU_OFS_IRQ_MASK):
            next_state.rdata[`IOPU_IRQ_WIDTH-1:0] = state.irq_mask;
          hit(paddr, `IOPU_OFS_SLEEP):
            next_state.rdata[`IOPU_SLEEP_BIT] = (state.power == IOPU_SLEEP);
          default:
            next_state.rdata = '0;
        endcase
      end
    end

    // register writes, low byte lane only
    if (wr_lane0) begin
      case (1'b1)
        hit(paddr, `IOPU_OFS_PA_DATA):
          next_state.pa_data = pwdata[`IOPU_PA_WIDTH-1:0];
        hit(paddr, `IOPU_OFS_PB_DATA):
          next_state.pb_data = pwdata[`IOPU_PB_WIDTH-1:0];
        hit(paddr, `IOPU_OFS_PA_DIR):
          next_state.pa_dir = pwdata[`IOPU_PA_WIDTH-1:0];
        hit(paddr, `IOPU_OFS_PB_DIR):
          next_state.pb_dir = pwdata[`IOPU_PB_WIDTH-1:0];
        hit(paddr, `IOPU_OFS_PA_PU):
          next_state.pa_pu = pwdata[`IOPU_PA_WIDTH-1:0] &
                             `IOPU_PA_PU_MASK;
        hit(paddr, `IOPU_OFS_PB_PU):
          next_state.pb_pu = pwdata[`IOPU_PB_WIDTH-1:0];
        hit(paddr, `IOPU_OFS_PA_WAKE):
          next_state.pa_wake = pwdata[`IOPU_PA_WIDTH-1:0];
        hit(paddr, `IOPU_OFS_IRQ_MASK):
          next_state.irq_mask = pwdata[`IOPU_IRQ_WIDTH-1:0];
        default: begin
        end
      endcase
    end

    // status: write one to clear, a new event wins over the clear
    if (wr_lane0 && hit(paddr, `IOPU_OFS_IRQ_STAT)) begin
      next_state.irq_stat = state.irq_stat & ~pwdata[`IOPU_IRQ_WIDTH-1:0];
    end
    next_state.irq_stat = next_state.irq_stat | irq_set;

    // power state
    case (state.power)
      IOPU_RUN: begin
        if (wr_lane0 && hit(paddr, `IOPU_OFS_SLEEP) &&
            pwdata[`IOPU_SLEEP_BIT]) begin
          next_state.power = IOPU_SLEEP;
        end
      end
      IOPU_SLEEP: begin
        if (pin_wake || wdt_sleep) begin
          next_state.power = IOPU_RUN;
        end
      end
      default:
        next_state.power = IOPU_RUN;
    endcase

    // watchdog while running restores the port defaults
    if (wdt_timeout && (state.power == IOPU_RUN)) begin
      next_state.pa_data = `IOPU_RST_PA_DATA;
      next_state.pb_data = `IOPU_RST_PB_DATA;
      next_state.pa_dir  = `IOPU_RST_PA_DIR;
      next_state.pb_dir  = `IOPU_RST_PB_DIR;
      next_state.pa_pu   = `IOPU_RST_PA_PU;
      next_state.pb_pu   = `IOPU_RST_PB_PU;
      next_state.pa_wake = `IOPU_RST_PA_WAKE;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.pa_data  <= `IOPU_RST_PA_DATA;
      state.pb_data  <= `IOPU_RST_PB_DATA;
      state.pa_dir   <= `IOPU_RST_PA_DIR;
      state.pb_dir   <= `IOPU_RST_PB_DIR;
      state.pa_pu    <= `IOPU_RST_PA_PU;
      state.pb_pu    <= `IOPU_RST_PB_PU;
      state.pa_wake  <= `IOPU_RST_PA_WAKE;
      state.irq_stat <= `IOPU_RST_IRQ;
      state.irq_mask <= `IOPU_RST_IRQ;
      state.power    <= IOPU_RUN;
      state.pa_meta  <= '0;
      state.pa_sync  <= '0;
      state.pa_prev  <= '0;
      state.pb_meta  <= '0;
      state.pb_sync  <= '0;
      state.rdata    <= '0;
      state.slverr   <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive and pull-ups
  // ----------------------------------------------------------------------
  // implemented pull-up positions, so the mask can be indexed per bit
  localparam logic [PA_WIDTH-1:0] pa_pu_impl = `IOPU_PA_PU_MASK;

  genvar i;
  for (i = 0; i < PA_WIDTH; i++) begin : g_pa
    assign porta_pin_out[i]   = state.pa_data[i];
    assign porta_pin_oe[i]    = ~state.pa_dir[i];
    assign porta_pullup_on[i] = state.pa_dir[i] & state.pa_pu[i] &
                                pa_pu_impl[i];
  end
  for (i = 0; i < PB_WIDTH; i++) begin : g_pb
    assign portb_pin_out[i]   = state.pb_data[i];
    assign portb_pin_oe[i]    = ~state.pb_dir[i];
    assign portb_pullup_on[i] = state.pb_dir[i] & state.pb_pu[i];
  end

  // ----------------------------------------------------------------------
  // bus answer and system outputs
  // ----------------------------------------------------------------------
  assign pready     = 1'b1;
  assign prdata     = state.rdata;
  assign pslverr    = psel & penable & state.slverr;
  assign sleep_mode = (state.power == IOPU_SLEEP);
  assign wake_event = pin_wake | wdt_sleep;
  assign irq        = (state.irq_stat & state.irq_mask) != '0;

endmodule

// >>> logic/iopu_defines.svh
// constants of the io port with pull-ups and wake-up
`ifndef IOPU_DEFINES_SVH
`define IOPU_DEFINES_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define IOPU_PA_WIDTH      8
`define IOPU_PB_WIDTH      2
`define IOPU_ADDR_WIDTH    8
`define IOPU_DATA_WIDTH    32
`define IOPU_IRQ_WIDTH     2

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define IOPU_OFS_PA_DATA   8'h00
`define IOPU_OFS_PB_DATA   8'h04
`define IOPU_OFS_PA_DIR    8'h08
`define IOPU_OFS_PB_DIR    8'h0C
`define IOPU_OFS_PA_PU     8'h10
`define IOPU_OFS_PB_PU     8'h14
`define IOPU_OFS_PA_WAKE   8'h18
`define IOPU_OFS_IRQ_STAT  8'h1C
`define IOPU_OFS_IRQ_MASK  8'h20
`define IOPU_OFS_SLEEP     8'h24

// ----------------------------------------------------------------------
// reset values and field layouts
// ----------------------------------------------------------------------
`define IOPU_RST_PA_DATA   8'hFF
`define IOPU_RST_PB_DATA   2'h3
`define IOPU_RST_PA_DIR    8'hFF
`define IOPU_RST_PB_DIR    2'h3
`define IOPU_RST_PA_PU     8'h00
`define IOPU_RST_PB_PU     2'h0
`define IOPU_RST_PA_WAKE   8'h00
`define IOPU_RST_IRQ       2'h0
`define IOPU_PA_PU_MASK    8'h7F
`define IOPU_IRQ_PIN_WAKE  0
`define IOPU_IRQ_WDT_WAKE  1
`define IOPU_SLEEP_BIT     0

`endif

// >>> logic/iopu_pkg.sv
// types of the io port with pull-ups and wake-up
`include "iopu_defines.svh"

package iopu_pkg;

  typedef enum logic {
    IOPU_RUN,
    IOPU_SLEEP
  } iopu_power_t;

  typedef struct packed {
    logic [`IOPU_PA_WIDTH-1:0]   pa_data;
    logic [`IOPU_PB_WIDTH-1:0]   pb_data;
    logic [`IOPU_PA_WIDTH-1:0]   pa_dir;
    logic [`IOPU_PB_WIDTH-1:0]   pb_dir;
    logic [`IOPU_PA_WIDTH-1:0]   pa_pu;
    logic [`IOPU_PB_WIDTH-1:0]   pb_pu;
    logic [`IOPU_PA_WIDTH-1:0]   pa_wake;
    logic [`IOPU_IRQ_WIDTH-1:0]  irq_stat;
    logic [`IOPU_IRQ_WIDTH-1:0]  irq_mask;
    iopu_power_t                 power;
    logic [`IOPU_PA_WIDTH-1:0]   pa_meta;
    logic [`IOPU_PA_WIDTH-1:0]   pa_sync;
    logic [`IOPU_PA_WIDTH-1:0]   pa_prev;
    logic [`IOPU_PB_WIDTH-1:0]   pb_meta;
    logic [`IOPU_PB_WIDTH-1:0]   pb_sync;
    logic [`IOPU_DATA_WIDTH-1:0] rdata;
    logic                        slverr;
  } iopu_state_t;

endpackage

// >>> tb/iopu_pins_model.sv
// pin-side circuitry model for one port
`timescale 1ns/1ps

module iopu_pins_model #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] pullup_on,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin_in
);
  logic [W-1:0] prev = '0;

  // a floating pin shows no stable level
  always @(posedge pclk) begin
    prev <= pin_in;
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pullup_on[i] ? 1'b1 : ~prev[i];
    end
  end
endmodule

// >>> tb/iopu_checker.sv
// port-level assertions for the io port block
`timescale 1ns/1ps
`include "iopu_defines.svh"

module iopu_checker #(
  parameter int PA_WIDTH = 8,
  parameter int PB_WIDTH = 2
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [`IOPU_ADDR_WIDTH-1:0] paddr,
  input wire logic [`IOPU_DATA_WIDTH-1:0] pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [`IOPU_DATA_WIDTH-1:0] prdata,
  input wire logic                        wdt_timeout,
  input wire logic [PA_WIDTH-1:0]         porta_pin_out,
  input wire logic [PA_WIDTH-1:0]         porta_pin_oe,
  input wire logic [PA_WIDTH-1:0]         porta_pullup_on,
  input wire logic [PB_WIDTH-1:0]         portb_pin_out,
  input wire logic [PB_WIDTH-1:0]         portb_pin_oe,
  input wire logic [PB_WIDTH-1:0]         portb_pullup_on,
  input wire logic                        sleep_mode,
  input wire logic                        wake_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite && pstrb[0];

  pa_pu_input_a: assert property ((porta_pullup_on & porta_pin_oe) == '0)
    else $error("port a pull-up on a driven pin");
  pb_pu_input_a: assert property ((portb_pullup_on & portb_pin_oe) == '0)
    else $error("port b pull-up on a driven pin");
  pa7_no_pu_a: assert property (!porta_pullup_on[PA_WIDTH-1])
    else $error("port a top bit pull-up on");
  pa_latch_a: assert property (!$stable(porta_pin_out) |->
    $past(wr && paddr == `IOPU_OFS_PA_DATA || wdt_timeout))
    else $error("port a latch changed without write");
  pb_latch_a: assert property (!$stable(portb_pin_out) |->
    $past(wr && paddr == `IOPU_OFS_PB_DATA || wdt_timeout))
    else $error("port b latch changed without write");
  pa_dir_hold_a: assert property (!$stable(porta_pin_oe) |->
    $past(wr && paddr == `IOPU_OFS_PA_DIR || wdt_timeout))
    else $error("port a direction changed without write");
  sleep_enter_a: assert property (wr && paddr == `IOPU_OFS_SLEEP &&
    pwdata[0] |=> sleep_mode)
    else $error("sleep not entered");
  wake_cause_a: assert property ($fell(sleep_mode) |-> $past(wake_event))
    else $error("sleep left without wake event");
  wake_exit_a: assert property (wake_event |-> sleep_mode ##1 !sleep_mode)
    else $error("wake event not followed by run");
  rd_upper_a: assert property (psel && penable && !pwrite |->
    prdata[`IOPU_DATA_WIDTH-1:8] == '0)
    else $error("upper read bits not zero");
endmodule

bind iopu_top iopu_checker #(.PA_WIDTH(PA_WIDTH), .PB_WIDTH(PB_WIDTH)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .wdt_timeout, .porta_pin_out, .porta_pin_oe, .porta_pullup_on,
  .portb_pin_out, .portb_pin_oe, .portb_pullup_on, .sleep_mode, .wake_event);

// >>> tb/test_io_port_pullup_wakeup.sv
// self-checking bench for the io port block
`timescale 1ns/1ps

module test_io_port_pullup_wakeup;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, wdt_timeout = 1'b0;
  logic [7:0]  paddr = 8'h00, ext_val = 8'hFF, ext_en = 8'hFF;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, sleep_mode, wake_event, irq, last_err;
  logic [7:0]  porta_pin_in, porta_pin_out, porta_pin_oe, porta_pullup_on;
  logic [1:0]  portb_pin_in, portb_pin_out, portb_pin_oe, portb_pullup_on;
  int          errors = 0, num_checks = 0;

  always #2 pclk = ~pclk;

  iopu_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .wdt_timeout, .porta_pin_in,
    .porta_pin_out, .porta_pin_oe, .porta_pullup_on, .portb_pin_in,
    .portb_pin_out, .portb_pin_oe, .portb_pullup_on, .sleep_mode,
    .wake_event, .irq);
  iopu_pins_model #(.W(8)) u_pa (.pclk, .pin_out(porta_pin_out),
    .pin_oe(porta_pin_oe), .pullup_on(porta_pullup_on), .ext_val,
    .ext_en, .pin_in(porta_pin_in));
  iopu_pins_model #(.W(2)) u_pb (.pclk, .pin_out(portb_pin_out),
    .pin_oe(portb_pin_oe), .pullup_on(portb_pullup_on), .ext_val(2'h0),
    .ext_en(2'h0), .pin_in(portb_pin_in));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait that never completes
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), exp, rd_q);
  endtask

  task automatic pulse_wdt;
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
  endtask

  task automatic wait_awake;
    for (int i = 0; i < 32 && sleep_mode !== 1'b0; i++) @(posedge pclk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    complete_run;
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("pa out", 8'hFF, porta_pin_out);
    chk("pa oe", 8'h00, porta_pin_oe);
    chk("pb oe", 2'h0, portb_pin_oe);
    rd(8'h08, 32'hFF);
    rd(8'h0C, 32'h3);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h00, 32'hFF);
    $display("test reset done");
    wr(8'h10, 32'hFF);
    wr(8'h14, 32'hFF);
    rd(8'h10, 32'h7F);
    rd(8'h14, 32'h3);
    pstrb <= 4'hE;
    wr(8'h18, 32'hFF);
    pstrb <= 4'hF;
    rd(8'h18, 32'h0);
    wr(8'h08, 32'hF0);
    @(negedge pclk);
    chk("pa pullup", 8'h70, porta_pullup_on);
    chk("pa oe", 8'h0F, porta_pin_oe);
    $display("test pullup done");
    wr(8'h00, 32'hA5);
    ext_en <= 8'hF0;
    ext_val <= 8'h3C;
    repeat (4) @(posedge pclk);
    rd(8'h00, 32'h35);
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'h2);
    @(negedge pclk);
    chk("pa out", 8'hA5, porta_pin_out);
    chk("pb oe", 2'h3, portb_pin_oe);
    chk("pb pullup", 2'h0, portb_pullup_on);
    rd(8'h04, 32'h2);
    rd(8'h30, 32'h0);
    chk("slverr", 1'b1, last_err);
    $display("test latch done");
    wr(8'h08, 32'hFF);
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    wr(8'h18, 32'h1);
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h1);
    ext_val <= 8'hFD;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    chk("sleep", 1'b1, sleep_mode);
    rd(8'h24, 32'h1);
    @(posedge pclk);
    ext_val <= 8'hFC;
    wait_awake;
    @(negedge pclk);
    chk("sleep", 1'b0, sleep_mode);
    chk("irq", 1'b1, irq);
    rd(8'h1C, 32'h1);
    rd(8'h24, 32'h0);
    wr(8'h20, 32'h0);
    @(negedge pclk);
    chk("irq", 1'b0, irq);
    wr(8'h20, 32'h1);
    rd(8'h20, 32'h1);
    wr(8'h1C, 32'h1);
    @(negedge pclk);
    chk("irq", 1'b0, irq);
    rd(8'h1C, 32'h0);
    $display("test wake done");
    wr(8'h24, 32'h1);
    pulse_wdt;
    wait_awake;
    @(negedge pclk);
    chk("sleep", 1'b0, sleep_mode);
    chk("pa out", 8'hA5, porta_pin_out);
    rd(8'h18, 32'h1);
    rd(8'h1C, 32'h2);
    pulse_wdt;
    rd(8'h18, 32'h0);
    @(negedge pclk);
    chk("pa out", 8'hFF, porta_pin_out);
    $display("test watchdog done");
    complete_run;
  end
endmodule
